// ### csc_params.svh
// Constants for the charger supervisor control block.
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
`define CSC_AW          8
`define CSC_OFF_CTRL    8'h00
`define CSC_OFF_MON     8'h04
`define CSC_OFF_STAT    8'h08
`define CSC_OFF_FLAG    8'h0C
`define CSC_OFF_MASK    8'h10
`define CSC_OFF_RES0    8'h14
`define CSC_NCH         10
`define CSC_NEV         7
`define CSC_NSYNC       14
`define CSC_CH_NONE     4'hF
`define CSC_B_OTG       0
`define CSC_B_DIS       1
`define CSC_B_G1        2
`define CSC_B_G2        3
`define CSC_B_PD1       4
`define CSC_B_PD2       5
`define CSC_B_PDB       6
`define CSC_B_CHG       7
`define CSC_B_BYP       8
`define CSC_B_RUN       9
`define CSC_B_CEN       0
`define CSC_B_ONE       1
`define CSC_B_AVG       2
`define CSC_B_SEED      3
`define CSC_F_CHDIS     16
`define CSC_F_ROLE      8
`define CSC_F_ADDR      16
`define CSC_F_SYNCIN    24
`define CSC_E_DONE      6
`define CSC_CLK_NS      8
`define CSC_RETRY_MS    760
`define CSC_IN_DEG_NS   10000
`define CSC_INT_NS      1000
`define CSC_SYNC_HALF   8'h08
`define CSC_STRAP_WAIT  2'h3
`endif

// ### csc_pkg.sv
// Types shared by the charger supervisor control block.
`include "csc_params.svh"
package csc_pkg;
  typedef enum logic [1:0] {CSC_STANDALONE, CSC_PRIMARY, CSC_SECONDARY} csc_role_t;
  typedef enum logic [1:0] {CSC_MON_IDLE, CSC_MON_REQ, CSC_MON_WAIT} csc_mon_t;
  typedef struct packed {
    logic [`CSC_NSYNC-1:0]        s1;
    logic [`CSC_NSYNC-1:0]        s2;
    logic [9:0]                   ctrl;
    logic [3:0]                   mon;
    logic [`CSC_NCH-1:0]          chdis;
    csc_mon_t                     mst;
    logic [3:0]                   ch;
    logic                         mstart;
    logic [`CSC_NCH-1:0]          seeded;
    logic [`CSC_NCH-1:0][15:0]    res;
    logic [`CSC_NEV-1:0]          flag;
    logic [`CSC_NEV-1:0]          mask;
    logic [`CSC_NEV-1:0]          prev;
    logic [15:0]                  int_cnt;
    logic [15:0]                  deg1;
    logic [15:0]                  deg2;
    logic [31:0]                  retry_cnt;
    logic                         retry;
    logic [1:0]                   strap_cnt;
    logic                         strap_done;
    csc_role_t                    role;
    logic [6:0]                   addr;
    logic [7:0]                   div;
    logic                         sync_clk;
    logic [31:0]                  prdata;
  } csc_state_t;
endpackage : csc_pkg

// ### csc_top.sv
// Charger supervisor control: gate drives, monitor sequencing, strap, events, APB registers.
// Function
// - Over-voltage on an input or bus drops that gate drive, OTG bit kept.
// - Ten-channel 16-bit monitor runs only while its enable bit is one.
// - Rate select picks continuous or one-shot conversion.
// - Averaging enable, off at reset; seed select picks old value or new sample.
// - Protection faults never stop monitoring; only the host enable does.
// - Conversions wait until input, bus or output is present.
// - One-shot sets done flag and clears enable on the same edge; continuous keeps done zero.
// - At power-on the strap gives serial address and role, role readable.
// - Strap bands map to address 0x65/0x66/0x67 and roles as tabled.
// - Primary drives sync output; secondary takes sync input.
// - Primary and standalone drive the input gate outputs; the secondary never does.
// - Event pin pulls low for a fixed time on an event.
// - Event sets status and flag; read clears flag, status follows condition.
// - A persisting event after flag clear raises no new pulse.
// - Mask suppresses the pulse but the flag still updates.
// - Gate turns on after input deglitch with disable-all zero; off on over-voltage.
// - Bus below 3V while active stops charge and flags a short.
// - After a short, wait 760ms then re-enable and restart.
// - Bypass: bus outside window clears charge enable and blocking switch.
// - Divider: low clears, high waits; in range starts and disables checks.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "csc_params.svh"
module csc_top #(
  parameter int RETRY_CYCLES = (`CSC_RETRY_MS * 1000000) / `CSC_CLK_NS,
  parameter int DEG_CYCLES   = (`CSC_IN_DEG_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS,
  parameter int INT_CYCLES   = (`CSC_INT_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`CSC_AW-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                input1_overvolt,
  input  wire logic                input2_overvolt,
  input  wire logic                bus_overvolt,
  input  wire logic                input1_present,
  input  wire logic                input2_present,
  input  wire logic                bus_present,
  input  wire logic                out_present,
  input  wire logic                bus_short_protect,
  input  wire logic                bus_range_low,
  input  wire logic                bus_range_high,
  input  wire logic [2:0]          strap_select_pin,
  input  wire logic                sync_in_pin,
  input  wire logic                monitor_sample_valid,
  input  wire logic [15:0]         monitor_sample,
  output logic                     monitor_power_on,
  output logic                     monitor_start,
  output logic [3:0]               monitor_channel,
  output logic                     input1_gate_drive,
  output logic                     input2_gate_drive,
  output logic                     input1_pulldown_enable,
  output logic                     input2_pulldown_enable,
  output logic                     bus_pulldown_enable,
  output logic                     blocking_switch,
  output logic                     charge_run,
  output logic [6:0]               serial_addr,
  output logic                     sync_out_pin_o,
  output logic                     sync_out_pin_oe,
  output logic                     event_pulse_n_o,
  output logic                     event_pulse_n_oe
);

  csc_pkg::csc_state_t r_ff;
  csc_pkg::csc_state_t nxt_r;

  // Next enabled channel at or after a start index, or none.
  function automatic logic [3:0] next_ch(input logic [`CSC_NCH-1:0] dis, input logic [4:0] from);
    logic [3:0] n;
    n = `CSC_CH_NONE;
    for (int i = `CSC_NCH - 1; i >= 0; i--) begin
      if (!dis[i] && (5'(i) >= from)) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction : next_ch

  // Synchronised views; bit order follows the concatenation below.
  logic       in1_ovp, in2_ovp, bus_ovp, in1_pres, in2_pres, bus_pres, out_pres;
  logic       bus_low, rng_lo, rng_hi, sync_in;
  logic [2:0] strap;
  assign {strap, sync_in, rng_hi, rng_lo, bus_low, out_pres, bus_pres, in2_pres, in1_pres,
          bus_ovp, in2_ovp, in1_ovp} = r_ff.s2;

  logic                 setup, access, secondary, g1_drv, g2_drv, any_pres;
  logic [`CSC_NEV-1:0]  stat;
  logic [`CSC_AW-1:0]   ridx;
  logic                 res_hit;
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign secondary = (r_ff.role == csc_pkg::CSC_SECONDARY);
  assign g1_drv    = r_ff.ctrl[`CSC_B_G1] && !r_ff.ctrl[`CSC_B_DIS] && !secondary;
  assign g2_drv    = r_ff.ctrl[`CSC_B_G2] && !r_ff.ctrl[`CSC_B_DIS] && !secondary;
  assign any_pres  = in1_pres || in2_pres || bus_pres || out_pres;
  assign ridx      = (paddr - `CSC_OFF_RES0) >> 2;
  assign res_hit   = (paddr >= `CSC_OFF_RES0) && (ridx < `CSC_AW'(`CSC_NCH))
                     && (paddr[1:0] == 2'h0);

  always_comb begin
    logic [3:0]  n;
    logic [16:0] sum;
    logic        done;
    logic        mapped;
    n      = `CSC_CH_NONE;
    sum    = 17'h00000;
    done   = 1'b0;
    mapped = 1'b0;
    nxt_r  = r_ff;
    nxt_r.s1 = {strap_select_pin, sync_in_pin, bus_range_high, bus_range_low,
                bus_short_protect, out_present, bus_present, input2_present,
                input1_present, bus_overvolt, input2_overvolt, input1_overvolt};
    nxt_r.s2 = r_ff.s1;
    nxt_r.mstart = 1'b0;

    // Strap is caught once the synchroniser has settled after reset.
    if (!r_ff.strap_done) begin
      nxt_r.strap_cnt = r_ff.strap_cnt + 2'h1;
      if (r_ff.strap_cnt == `CSC_STRAP_WAIT) begin
        nxt_r.strap_done = 1'b1;
        unique case (strap)
          3'h1:    begin nxt_r.addr = 7'h67; nxt_r.role = csc_pkg::CSC_STANDALONE; end
          3'h2:    begin nxt_r.addr = 7'h66; nxt_r.role = csc_pkg::CSC_SECONDARY;  end
          3'h3:    begin nxt_r.addr = 7'h66; nxt_r.role = csc_pkg::CSC_PRIMARY;    end
          3'h4:    begin nxt_r.addr = 7'h66; nxt_r.role = csc_pkg::CSC_STANDALONE; end
          3'h5:    begin nxt_r.addr = 7'h67; nxt_r.role = csc_pkg::CSC_SECONDARY;  end
          3'h6:    begin nxt_r.addr = 7'h65; nxt_r.role = csc_pkg::CSC_PRIMARY;    end
          default: begin nxt_r.addr = 7'h65; nxt_r.role = csc_pkg::CSC_STANDALONE; end
        endcase
      end
    end

    // Register writes take effect at the access edge; hardware updates below win.
    if (access && pwrite) begin
      unique case (paddr)
        `CSC_OFF_CTRL: begin
          nxt_r.ctrl[8:0] = pwdata[8:0];
          if (pwdata[`CSC_B_OTG] && !r_ff.ctrl[`CSC_B_OTG]) begin
            nxt_r.ctrl[`CSC_B_DIS] = 1'b1;
          end
        end
        `CSC_OFF_MON: begin
          nxt_r.mon   = pwdata[3:0];
          nxt_r.chdis = pwdata[`CSC_F_CHDIS +: `CSC_NCH];
        end
        `CSC_OFF_MASK: nxt_r.mask = pwdata[`CSC_NEV-1:0];
        default: ;
      endcase
    end

    // Disable-all forces both gate-on bits low; once it clears, the deglitch turn-on below can set one again.
    if (nxt_r.ctrl[`CSC_B_DIS]) begin
      nxt_r.ctrl[`CSC_B_G1] = 1'b0;
      nxt_r.ctrl[`CSC_B_G2] = 1'b0;
    end

    // Input deglitch counters run while the input is present and not over-voltage.
    nxt_r.deg1 = (in1_pres && !in1_ovp) ?
                 ((r_ff.deg1 == 16'(DEG_CYCLES)) ? r_ff.deg1 : r_ff.deg1 + 16'h0001) : 16'h0000;
    nxt_r.deg2 = (in2_pres && !in2_ovp) ?
                 ((r_ff.deg2 == 16'(DEG_CYCLES)) ? r_ff.deg2 : r_ff.deg2 + 16'h0001) : 16'h0000;
    if (!r_ff.ctrl[`CSC_B_OTG] && !nxt_r.ctrl[`CSC_B_DIS] && !nxt_r.ctrl[`CSC_B_G1]
        && !nxt_r.ctrl[`CSC_B_G2]) begin
      if (r_ff.deg1 == 16'(DEG_CYCLES)) begin
        nxt_r.ctrl[`CSC_B_G1] = 1'b1;
      end else if (r_ff.deg2 == 16'(DEG_CYCLES)) begin
        nxt_r.ctrl[`CSC_B_G2] = 1'b1;
      end
    end
    // Over-voltage drops the gate but leaves the OTG bit alone.
    if (in1_ovp || bus_ovp) begin
      nxt_r.ctrl[`CSC_B_G1] = 1'b0;
    end
    if (in2_ovp || bus_ovp) begin
      nxt_r.ctrl[`CSC_B_G2] = 1'b0;
    end

    // Bus short shutdown and timed automatic retry.
    if (r_ff.retry) begin
      nxt_r.retry_cnt = r_ff.retry_cnt + 32'h00000001;
      nxt_r.ctrl[`CSC_B_CHG] = 1'b0;
      if (r_ff.retry_cnt == 32'(RETRY_CYCLES - 1)) begin
        nxt_r.retry = 1'b0;
        nxt_r.ctrl[`CSC_B_CHG] = 1'b1;
      end
    end else if ((g1_drv || g2_drv || bus_pres) && bus_low) begin
      nxt_r.retry = 1'b1;
      nxt_r.retry_cnt = 32'h00000000;
      nxt_r.ctrl[`CSC_B_CHG] = 1'b0;
    end

    // Bus charge-window checks during charge initiation only.
    if (!nxt_r.ctrl[`CSC_B_CHG]) begin
      nxt_r.ctrl[`CSC_B_RUN] = 1'b0;
    end else if (!r_ff.ctrl[`CSC_B_RUN] && r_ff.ctrl[`CSC_B_CHG]) begin
      if (rng_lo || (rng_hi && r_ff.ctrl[`CSC_B_BYP])) begin
        nxt_r.ctrl[`CSC_B_CHG] = 1'b0;
      end else if (!rng_hi) begin
        nxt_r.ctrl[`CSC_B_RUN] = 1'b1;
      end
    end

    // Monitor sequencer; faults never touch it, only the enable bit does.
    unique case (r_ff.mst)
      csc_pkg::CSC_MON_IDLE: begin
        if (r_ff.mon[`CSC_B_CEN] && any_pres) begin
          n = next_ch(r_ff.chdis, 5'h00);
          if (n == `CSC_CH_NONE) begin
            done = r_ff.mon[`CSC_B_ONE];
          end else begin
            nxt_r.ch  = n;
            nxt_r.mst = csc_pkg::CSC_MON_REQ;
          end
        end
      end
      csc_pkg::CSC_MON_REQ: begin
        if (any_pres) begin
          nxt_r.mstart = 1'b1;
          nxt_r.mst = csc_pkg::CSC_MON_WAIT;
        end
      end
      csc_pkg::CSC_MON_WAIT: begin
        if (monitor_sample_valid) begin
          sum = {1'b0, r_ff.res[r_ff.ch]} + {1'b0, monitor_sample};
          if (r_ff.mon[`CSC_B_AVG] && (r_ff.seeded[r_ff.ch] || !r_ff.mon[`CSC_B_SEED])) begin
            nxt_r.res[r_ff.ch] = sum[16:1];
          end else begin
            nxt_r.res[r_ff.ch] = monitor_sample;
          end
          nxt_r.seeded[r_ff.ch] = r_ff.mon[`CSC_B_AVG];
          n = next_ch(r_ff.chdis, {1'b0, r_ff.ch} + 5'h01);
          if (n == `CSC_CH_NONE) begin
            done = r_ff.mon[`CSC_B_ONE];
            nxt_r.mst = csc_pkg::CSC_MON_IDLE;
          end else begin
            nxt_r.ch  = n;
            nxt_r.mst = csc_pkg::CSC_MON_REQ;
          end
        end
      end
    endcase
    if (done) begin
      nxt_r.mon[`CSC_B_CEN] = 1'b0;
    end
    // A start must never reach a converter that is being powered down in the same cycle.
    if (!nxt_r.mon[`CSC_B_CEN]) begin
      nxt_r.mst    = csc_pkg::CSC_MON_IDLE;
      nxt_r.mstart = 1'b0;
    end
    if (!nxt_r.mon[`CSC_B_AVG]) begin
      nxt_r.seeded = '0;
    end

    // Events: flag set on each new event, cleared by reading; set wins.
    stat = {done, rng_hi && !r_ff.ctrl[`CSC_B_RUN], rng_lo && !r_ff.ctrl[`CSC_B_RUN],
            r_ff.retry, bus_ovp, in2_ovp, in1_ovp};
    nxt_r.prev = stat;
    if (access && !pwrite && (paddr == `CSC_OFF_FLAG)) begin
      nxt_r.flag = '0;
    end
    nxt_r.flag = nxt_r.flag | (stat & ~r_ff.prev);
    if (r_ff.int_cnt != 16'h0000) begin
      nxt_r.int_cnt = r_ff.int_cnt - 16'h0001;
    end
    // Only a fresh unmasked event starts a pulse; a held one does not.
    // An event that arrives while the pin is already low joins that pulse, so the
    // width stays fixed and the host still finds its flag when it services the pulse.
    if (((stat & ~r_ff.prev & ~r_ff.mask) != '0)
        && (r_ff.int_cnt == 16'h0000)) begin
      nxt_r.int_cnt = 16'(INT_CYCLES);
    end

    // Sync output divider for the primary role.
    nxt_r.div = r_ff.div + 8'h01;
    if (r_ff.div == `CSC_SYNC_HALF - 8'h01) begin
      nxt_r.div = 8'h00;
      nxt_r.sync_clk = !r_ff.sync_clk;
    end

    // Read data is prepared in the setup cycle and stands during access.
    if (setup) begin
      nxt_r.prdata = 32'h00000000;
      unique case (paddr)
        `CSC_OFF_CTRL: nxt_r.prdata[9:0] = r_ff.ctrl;
        `CSC_OFF_MON: begin
          nxt_r.prdata[3:0] = r_ff.mon;
          nxt_r.prdata[`CSC_F_CHDIS +: `CSC_NCH] = r_ff.chdis;
        end
        `CSC_OFF_STAT: begin
          nxt_r.prdata[`CSC_NEV-2:0] = stat[`CSC_NEV-2:0];
          nxt_r.prdata[`CSC_F_ROLE +: 2] = r_ff.role;
          nxt_r.prdata[`CSC_F_ADDR +: 7] = r_ff.addr;
          nxt_r.prdata[`CSC_F_SYNCIN] = sync_in && secondary;
        end
        `CSC_OFF_FLAG: nxt_r.prdata[`CSC_NEV-1:0] = r_ff.flag;
        `CSC_OFF_MASK: nxt_r.prdata[`CSC_NEV-1:0] = r_ff.mask;
        default: begin
          if (res_hit) begin
            nxt_r.prdata[15:0] = r_ff.res[ridx[3:0]];
          end
        end
      endcase
    end
    mapped = res_hit || (paddr == `CSC_OFF_CTRL) || (paddr == `CSC_OFF_MON)
             || (paddr == `CSC_OFF_STAT) || (paddr == `CSC_OFF_FLAG)
             || (paddr == `CSC_OFF_MASK);
    pslverr = access && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata                 = r_ff.prdata;
  assign pready                 = 1'b1;
  assign monitor_power_on       = r_ff.mon[`CSC_B_CEN];
  assign monitor_start          = r_ff.mstart;
  assign monitor_channel        = r_ff.ch;
  assign input1_gate_drive      = g1_drv;
  assign input2_gate_drive      = g2_drv;
  assign input1_pulldown_enable = r_ff.ctrl[`CSC_B_PD1];
  assign input2_pulldown_enable = r_ff.ctrl[`CSC_B_PD2];
  assign bus_pulldown_enable    = r_ff.ctrl[`CSC_B_PDB];
  assign blocking_switch        = r_ff.ctrl[`CSC_B_CHG];
  assign charge_run             = r_ff.ctrl[`CSC_B_RUN];
  assign serial_addr            = r_ff.addr;
  assign sync_out_pin_o         = r_ff.sync_clk;
  assign sync_out_pin_oe        = (r_ff.role == csc_pkg::CSC_PRIMARY);
  assign event_pulse_n_o        = 1'b0;
  assign event_pulse_n_oe       = (r_ff.int_cnt != 16'h0000);

endmodule : csc_top
`default_nettype wire

// ### csc_top_props.sv
// Concurrent assertions on the ports of the charger supervisor control block.
`timescale 1ns/1ps
`default_nettype none
`include "csc_params.svh"
module csc_top_props #(
  parameter int INT_CYCLES = 125
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [`CSC_AW-1:0] paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               input1_overvolt,
  input wire logic               input2_overvolt,
  input wire logic               input1_gate_drive,
  input wire logic               input2_gate_drive,
  input wire logic               monitor_start,
  input wire logic               monitor_power_on,
  input wire logic               bus_short_protect,
  input wire logic               bus_present,
  input wire logic               blocking_switch,
  input wire logic               event_pulse_n_o,
  input wire logic               event_pulse_n_oe
);
  logic [15:0] int_len_ff;
  // Counts how long the event pin has been held low so the pulse width can be judged at its end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_len_ff <= 16'h0000;
    else int_len_ff <= event_pulse_n_oe ? int_len_ff + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h38 |-> pslverr)
    else $error("unmapped access not refused");
  AST_OVP_GATE1: assert property (input1_overvolt [*5] |-> !input1_gate_drive)
    else $error("first gate drive on during over-voltage");
  AST_OVP_GATE2: assert property (input2_overvolt [*5] |-> !input2_gate_drive)
    else $error("second gate drive on during over-voltage");
  AST_MON_POWER: assert property (monitor_start |-> monitor_power_on)
    else $error("conversion started while converter off");
  AST_INT_WIDTH: assert property ($fell(event_pulse_n_oe) |-> int_len_ff == INT_CYCLES)
    else $error("event pulse has wrong width");
  AST_INT_DRAIN: assert property (event_pulse_n_oe |-> !event_pulse_n_o)
    else $error("event pin driven high");
  AST_SHORT: assert property ((bus_short_protect && bus_present) [*5] |-> !blocking_switch)
    else $error("blocking switch on during bus short");
endmodule : csc_top_props
bind csc_top csc_top_props #(.INT_CYCLES(INT_CYCLES)) csc_top_props_i (.*);
`default_nettype wire

// ### csc_mon_model.sv
// Behavioural model of the monitoring converter behind the block.
`timescale 1ns/1ps
`default_nettype none
module csc_mon_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       monitor_start,
  input  wire logic       monitor_power_on,
  input  wire logic [3:0] monitor_channel,
  input  wire logic [3:0] mon_delay,
  output logic            monitor_sample_valid,
  output logic [15:0]     monitor_sample
);
  logic [3:0] wait_ff;
  // Between answers the data lines wander, so a stale sample never passes for a fresh one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 4'h0;
      monitor_sample_valid <= 1'b0;
      monitor_sample <= 16'h0000;
    end else begin
      monitor_sample_valid <= 1'b0;
      monitor_sample <= ~monitor_sample;
      if (!monitor_power_on) begin
        wait_ff <= 4'h0;
      end else if (monitor_start) begin
        wait_ff <= mon_delay;
      end else if (wait_ff == 4'h1) begin
        wait_ff <= 4'h0;
        monitor_sample_valid <= 1'b1;
        // The sample carries the programmed delay so that averaging sees two distinct values.
        monitor_sample <= {mon_delay, 8'h00, monitor_channel};
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
    end
  end
endmodule : csc_mon_model
`default_nettype wire

// ### charger_supervisor_control_test.sv
// Directed testbench for the charger supervisor control block.
`timescale 1ns/1ps
`default_nettype none
`include "csc_params.svh"
module charger_supervisor_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_q, sync_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic input1_overvolt, input2_overvolt, bus_overvolt, input1_present, input2_present;
  logic bus_present, out_present, bus_short_protect, bus_range_low, bus_range_high;
  logic sync_in_pin, monitor_sample_valid, monitor_power_on, monitor_start, charge_run;
  logic input1_gate_drive, input2_gate_drive, input1_pulldown_enable, input2_pulldown_enable;
  logic bus_pulldown_enable, blocking_switch, sync_out_pin_o, sync_out_pin_oe;
  logic event_pulse_n_o, event_pulse_n_oe;
  logic [2:0] strap_select_pin;
  logic [15:0] monitor_sample;
  logic [3:0] monitor_channel, mon_delay;
  logic [6:0] serial_addr;
  int mismatches, total_checks, pulses, starts, p0;
  localparam logic [6:0] SADDR [8] = '{7'h65, 7'h67, 7'h66, 7'h66, 7'h66, 7'h67, 7'h65, 7'h65};
  localparam logic [1:0] SROLE [8] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
  // The open-drain event line idles high through its pull-up.
  wire logic event_line = event_pulse_n_oe ? event_pulse_n_o : 1'b1;
  csc_top #(.RETRY_CYCLES(50), .DEG_CYCLES(4)) csc_top_i (.*);
  csc_mon_model csc_mon_model_i (.*);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    line_q <= event_line;
    if (line_q && !event_line) pulses <= pulses + 1;
    if (monitor_start) starts <= starts + 1;
  end
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    cmp(32'(pslverr), 32'(a > 8'h38));
    if (pready !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    cmp(q & m, e);
  endtask : rdc
  task automatic do_reset();
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    cyc(8);
  endtask : do_reset
  initial begin
    {psel, penable, pwrite, paddr, pwdata, input1_overvolt, input2_overvolt, bus_overvolt,
     input1_present, input2_present, bus_present, out_present, bus_short_protect,
     bus_range_low, bus_range_high} = '0;
    sync_in_pin = 1'b1;
    mon_delay = 4'h2;
    strap_select_pin = 3'h0;
    presetn = 1'b0;
    r = 32'h1;
    for (int s = 0; s < 8; s++) begin
      strap_select_pin <= 3'(s);
      do_reset();
      rdc(`CSC_OFF_STAT, 32'h017F_0300, (32'(SROLE[s] == 2'h2) << 24) |
          (32'(SADDR[s]) << 16) | (32'(SROLE[s]) << 8));
      cmp(32'(serial_addr), 32'(SADDR[s]));
      cmp(32'(sync_out_pin_oe), 32'(SROLE[s] == 2'h1));
      wr(`CSC_OFF_CTRL, 32'h1);
      wr(`CSC_OFF_CTRL, 32'h5);
      cyc(3);
      cmp(32'(input1_gate_drive), 32'(SROLE[s] != 2'h2));
    end
    strap_select_pin <= 3'h3;
    do_reset();
    sync_q = sync_out_pin_o;
    cyc(8);
    cmp(32'(sync_out_pin_o), 32'(!sync_q));
    p0 = pulses;
    rdc(`CSC_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdc(`CSC_OFF_MON, 32'hFFFF_FFFF, 32'h0);
    rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
    wr(`CSC_OFF_CTRL, 32'h1);
    rdc(`CSC_OFF_CTRL, 32'h3, 32'h3);
    wr(`CSC_OFF_CTRL, 32'h5);
    cyc(3);
    cmp(32'(input1_gate_drive), 32'h1);
    input1_overvolt <= 1'b1;
    cyc(6);
    cmp(32'(input1_gate_drive), 32'h0);
    cmp(32'(pulses - p0), 32'h1);
    rdc(`CSC_OFF_CTRL, 32'h1, 32'h1);
    rdc(`CSC_OFF_FLAG, 32'h1, 32'h1);
    rdc(`CSC_OFF_FLAG, 32'h1, 32'h0);
    rdc(`CSC_OFF_STAT, 32'h1, 32'h1);
    cyc(150);
    cmp(32'(pulses - p0), 32'h1);
    input1_overvolt <= 1'b0;
    cyc(8);
    cmp(32'(input1_gate_drive), 32'h0);
    wr(`CSC_OFF_CTRL, 32'hD);
    cyc(3);
    cmp(32'(input1_gate_drive), 32'h1);
    cmp(32'(input2_gate_drive), 32'h1);
    wr(`CSC_OFF_MASK, 32'h2);
    input2_overvolt <= 1'b1;
    cyc(8);
    cmp(32'(input2_gate_drive), 32'h0);
    cmp(32'(pulses - p0), 32'h1);
    rdc(`CSC_OFF_FLAG, 32'h2, 32'h2);
    input2_overvolt <= 1'b0;
    wr(`CSC_OFF_CTRL, 32'h7);
    cmp(32'(input1_gate_drive), 32'h0);
    wr(`CSC_OFF_CTRL, 32'h73);
    cmp({29'h0, input1_pulldown_enable, input2_pulldown_enable, bus_pulldown_enable}, 32'h7);
    wr(`CSC_OFF_CTRL, 32'h0);
    rdc(`CSC_OFF_CTRL, 32'h1, 32'h0);
    wr(`CSC_OFF_MON, 32'h0200_0003);
    cyc(30);
    cmp(32'(starts), 32'h0);
    out_present <= 1'b1;
    bus_present <= 1'b1;
    for (int i = 0; i < 100 && r[0] !== 1'b0; i++) apb(1'b0, `CSC_OFF_MON, 32'h0, r);
    cmp(r & 32'h1, 32'h0);
    if (r[0] !== 1'b0) print_verdict();
    rdc(`CSC_OFF_FLAG, 32'h40, 32'h40);
    cmp(32'(starts), 32'h9);
    rdc(`CSC_OFF_RES0, 32'hFFFF_FFFF, 32'h2000);
    rdc(8'h34, 32'hFFFF_FFFF, 32'h2008);
    rdc(8'h38, 32'hFFFF_FFFF, 32'h0);
    mon_delay <= 4'h9;
    wr(`CSC_OFF_MON, 32'h1);
    cyc(100);
    input1_overvolt <= 1'b1;
    cyc(60);
    rdc(`CSC_OFF_MON, 32'h1, 32'h1);
    rdc(`CSC_OFF_FLAG, 32'h40, 32'h0);
    cmp(32'(starts > 15), 32'h1);
    input1_overvolt <= 1'b0;
    wr(`CSC_OFF_MON, 32'h0);
    cmp(32'(monitor_power_on), 32'h0);
    mon_delay <= 4'h3;
    r = 32'h1;
    wr(`CSC_OFF_MON, 32'h0200_0007);
    for (int i = 0; i < 100 && r[0] !== 1'b0; i++) apb(1'b0, `CSC_OFF_MON, 32'h0, r);
    cmp(r & 32'h1, 32'h0);
    rdc(`CSC_OFF_RES0, 32'hFFFF_FFFF, 32'h6000);
    bus_range_high <= 1'b1;
    wr(`CSC_OFF_CTRL, 32'h80);
    cyc(6);
    cmp({30'h0, blocking_switch, charge_run}, 32'h2);
    bus_range_high <= 1'b0;
    bus_range_low <= 1'b1;
    cyc(6);
    cmp(32'(blocking_switch), 32'h0);
    bus_range_low <= 1'b0;
    bus_range_high <= 1'b1;
    wr(`CSC_OFF_CTRL, 32'h180);
    cyc(6);
    cmp(32'(blocking_switch), 32'h0);
    bus_range_high <= 1'b0;
    wr(`CSC_OFF_CTRL, 32'h80);
    cyc(6);
    cmp(32'(charge_run), 32'h1);
    bus_range_low <= 1'b1;
    cyc(6);
    cmp(32'(blocking_switch), 32'h1);
    bus_range_low <= 1'b0;
    bus_short_protect <= 1'b1;
    cyc(6);
    cmp(32'(blocking_switch), 32'h0);
    rdc(`CSC_OFF_STAT, 32'h8, 32'h8);
    rdc(`CSC_OFF_FLAG, 32'h8, 32'h8);
    bus_short_protect <= 1'b0;
    cyc(20);
    cmp(32'(blocking_switch), 32'h0);
    cyc(40);
    cmp(32'(blocking_switch), 32'h1);
    wr(`CSC_OFF_CTRL, 32'h82);
    input1_present <= 1'b1;
    cyc(10);
    cmp(32'(input1_gate_drive), 32'h0);
    wr(`CSC_OFF_CTRL, 32'h80);
    cmp(32'(input1_gate_drive), 32'h1);
    print_verdict();
  end
endmodule : charger_supervisor_control_test
`default_nettype wire
